// [design/asc_pkg.sv]
package asc_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_STATUS   = 8'h00;
	localparam logic [7:0] ADDR_CONTROL  = 8'h04;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;

	// ----------------------------------------------------------------
	// Status bit positions
	// ----------------------------------------------------------------
	localparam int ST_WINDOW    = 0;
	localparam int ST_REG_DONE  = 1;
	localparam int ST_INJ_DONE  = 2;
	localparam int ST_INJ_BEGIN = 3;
	localparam int ST_REG_BEGIN = 4;
	localparam int ST_ANY_DONE  = 5;
	localparam int ST_ANY_INJ   = 6;
	localparam int ST_WIDTH     = 7;

	// ----------------------------------------------------------------
	// Control fields
	// ----------------------------------------------------------------
	localparam int CT_MON_REG   = 23;
	localparam int CT_MON_INJ   = 22;
	localparam int CT_PAIR_HI   = 19;
	localparam int CT_PAIR_LO   = 16;
	localparam int CT_BURST_HI  = 15;
	localparam int CT_BURST_LO  = 13;
	localparam int CT_BURST_EN  = 11;

	localparam logic [31:0] CTRL_WMASK   = 32'h00cf_ffff;
	localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
	localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
	localparam logic [3:0]  PAIR_INDEP   = 4'h0;

endpackage

// [design/asc_regs.sv]
// The strobed register port is this design's own decision.
`timescale 1ns/1ps

module asc_regs #(
	parameter int DATA_W = 12
) (
	input  wire logic                sys_clk,
	input  wire logic                srst,
	input  wire logic [7:0]          addr,
	input  wire logic [31:0]         wdata,
	input  wire logic                wr_stb,
	input  wire logic                rd_stb,
	output logic      [31:0]         rdata,
	input  wire logic                reg_conv_start,
	input  wire logic                reg_conv_end,
	input  wire logic                reg_seq_end,
	input  wire logic                inj_seq_start,
	input  wire logic                inj_conv_end,
	input  wire logic                inj_seq_end,
	input  wire logic [DATA_W-1:0]   conv_result,
	input  wire logic [DATA_W-1:0]   low_threshold,
	input  wire logic [DATA_W-1:0]   high_threshold,
	input  wire logic                ext_trigger,
	output logic                     burst_done,
	output logic                     independent_mode,
	output logic                     irq
);
	import asc_pkg::*;

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [ST_WIDTH-1:0] status_ff;
	logic [ST_WIDTH-1:0] nxt_status;
	logic [ST_WIDTH-1:0] mask_ff;
	logic [31:0]         ctrl_ff;
	logic [ST_WIDTH-1:0] hw_set;
	logic [ST_WIDTH-1:0] sw_clr;
	logic                out_of_window;
	logic                mon_hit;
	logic [3:0]          burst_left_ff;
	logic                burst_active_ff;
	logic [3:0]          burst_total;

	// ----------------------------------------------------------------
	// Event capture
	// ----------------------------------------------------------------
	assign out_of_window = (conv_result < low_threshold) ||
		(conv_result > high_threshold);
	assign mon_hit = out_of_window &&
		((reg_conv_end && ctrl_ff[CT_MON_REG]) ||
		 (inj_conv_end && ctrl_ff[CT_MON_INJ]));

	always_comb begin
		hw_set               = '0;
		hw_set[ST_ANY_INJ]   = inj_conv_end;
		hw_set[ST_ANY_DONE]  = reg_conv_end | inj_conv_end;
		hw_set[ST_REG_BEGIN] = reg_conv_start;
		hw_set[ST_INJ_BEGIN] = inj_seq_start;
		hw_set[ST_INJ_DONE]  = inj_seq_end;
		hw_set[ST_REG_DONE]  = reg_seq_end;
		hw_set[ST_WINDOW]    = mon_hit;
	end

	// Clear only on zero bits of a status write
	assign sw_clr = (wr_stb && addr == ADDR_STATUS) ?
		~wdata[ST_WIDTH-1:0] : '0;

	// Set beats clear so no event is lost
	assign nxt_status = (status_ff & ~sw_clr) | hw_set;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			status_ff <= STATUS_RESET[ST_WIDTH-1:0];
		end else begin
			status_ff <= nxt_status;
		end
	end

	// ----------------------------------------------------------------
	// Control and mask
	// ----------------------------------------------------------------
	// Reserved bits held at zero whatever software writes
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ctrl_ff <= CTRL_RESET;
		end else if (wr_stb && addr == ADDR_CONTROL) begin
			ctrl_ff <= wdata & CTRL_WMASK;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			mask_ff <= '0;
		end else if (wr_stb && addr == ADDR_IRQ_MASK) begin
			mask_ff <= wdata[ST_WIDTH-1:0];
		end
	end

	assign irq = |(status_ff & mask_ff);

	// Only independent operation exists; any nonzero code deasserts independent_mode
	assign independent_mode =
		(ctrl_ff[CT_PAIR_HI:CT_PAIR_LO] == PAIR_INDEP);

	// ----------------------------------------------------------------
	// Discontinuous burst counter
	// ----------------------------------------------------------------
	assign burst_total =
		{1'b0, ctrl_ff[CT_BURST_HI:CT_BURST_LO]} + 4'h1;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			burst_left_ff   <= 4'h0;
			burst_active_ff <= 1'b0;
			burst_done      <= 1'b0;
		end else begin
			burst_done <= 1'b0;
			if (!ctrl_ff[CT_BURST_EN]) begin
				burst_active_ff <= 1'b0;
				burst_left_ff   <= 4'h0;
			end else if (ext_trigger && !burst_active_ff) begin
				burst_active_ff <= 1'b1;
				burst_left_ff   <= burst_total;
			end else if (burst_active_ff && reg_conv_end) begin
				if (burst_left_ff == 4'h1) begin
					burst_active_ff <= 1'b0;
					burst_done      <= 1'b1;
				end
				burst_left_ff <= burst_left_ff - 4'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rdata <= '0;
		end else if (rd_stb) begin
			if (addr == ADDR_STATUS) begin
				rdata <= {{(32-ST_WIDTH){1'b0}}, status_ff};
			end else if (addr == ADDR_CONTROL) begin
				rdata <= ctrl_ff;
			end else if (addr == ADDR_IRQ_MASK) begin
				rdata <= {{(32-ST_WIDTH){1'b0}}, mask_ff};
			end else begin
				rdata <= '0;
			end
		end else begin
			rdata <= '0;
		end
	end

endmodule // asc_regs

// [test/asc_regs_assertions.sv]
`timescale 1ns/1ps
module asc_regs_assertions (
	input wire logic        sys_clk, srst, rd_stb, wr_stb, burst_done,
	input wire logic        reg_conv_start, reg_conv_end, reg_seq_end,
	input wire logic        inj_seq_start, inj_conv_end, inj_seq_end,
	input wire logic [7:0]  addr,
	input wire logic [31:0] rdata
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	sequence s_rd(a); rd_stb && addr == a; endsequence
	// Event, a quiet cycle with no write, then a status read
	property p(e, int b);
		e ##1 !wr_stb ##1 s_rd(8'h00) |=> rdata[b];
	endproperty
	chk_any_inj: assert property (p(inj_conv_end,6)) else $error("bad");
	chk_any_done: assert property (p(reg_conv_end,5)) else $error("bad");
	chk_reg_begin: assert property (p(reg_conv_start,4)) else $error("bad");
	chk_inj_begin: assert property (p(inj_seq_start,3)) else $error("bad");
	chk_inj_done: assert property (p(inj_seq_end,2)) else $error("bad");
	chk_reg_done: assert property (p(reg_seq_end,1)) else $error("bad");
	chk_ctrl_rsvd: assert property (s_rd(8'h04) |=>
		!(rdata & 32'hff30_0000)) else $error("bad");
	chk_burst_once: assert property (burst_done |=> !burst_done)
		else $error("bad");
endmodule // asc_regs_assertions

// [test/asc_regs_tb.sv]
`timescale 1ns/1ps
module asc_regs_tb;
	import asc_pkg::*;
	logic        sys_clk = 0, srst = 1, wr_stb = 0, rd_stb = 0;
	logic [7:0]  addr = 0;
	logic [6:0]  ev = 0;
	logic [11:0] res = 0;
	logic [11:0] lo = 0, hi = 0;
	logic [31:0] wdata = 0, rdata;
	logic        burst_done, independent_mode, irq;
	logic [31:0] fl [6] = '{32'h10, 32'h20, 32'h02, 32'h08, 32'h60, 32'h04};
	int          error_cnt = 0, total_checks = 0, cyc = 0, n, r;
	always #50 sys_clk = ~sys_clk;
	asc_regs DUT (.sys_clk, .srst, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
		.reg_conv_start(ev[0]), .reg_conv_end(ev[1]), .reg_seq_end(ev[2]),
		.inj_seq_start(ev[3]), .inj_conv_end(ev[4]), .inj_seq_end(ev[5]),
		.conv_result(res), .low_threshold(lo), .high_threshold(hi),
		.ext_trigger(ev[6]), .burst_done, .independent_mode, .irq);
	task automatic chk(logic [31:0] g, x);
		total_checks++;
		if (g !== x) $display("unexpected %0t got %h want %h", $time, g, x);
		error_cnt += g !== x;
	endtask
	task automatic bus(bit w, logic [7:0] a, logic [31:0] d);
		@(posedge sys_clk) {addr, wdata, wr_stb, rd_stb} <= {a, d, w, !w};
		@(posedge sys_clk) {wr_stb, rd_stb} <= 2'h0;
		#1;
		if (!w) chk(rdata, d);
	endtask
	task automatic pulse(int i);
		@(posedge sys_clk) ev[i] <= 1'h1;
		@(posedge sys_clk) ev <= 7'h00;
		#1;
	endtask
	task automatic end_of_test(int t = 0);
		error_cnt += t;
		$display("errors %0d checks %0d", error_cnt, total_checks);
		if (error_cnt == 0 && total_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	always @(posedge sys_clk) if (++cyc == 9000) end_of_test(1);
	initial begin
		r = $urandom(32'h945edc9f);
		lo <= 12'h040 + 12'($urandom % 64);
		hi <= 12'h0c0 + 12'($urandom % 64);
		repeat (20) @(posedge sys_clk);
		srst <= 0;
		bus(0, ADDR_STATUS, 0);
		bus(0, ADDR_CONTROL, 0);
		for (int k = 0; k < 3; k++) begin
			// Software keeps reserved bits and pairing code at zero
			r = (k ? $urandom : -1) & CTRL_WMASK & ~32'h000f_0000;
			bus(1, ADDR_CONTROL, r);
			bus(0, ADDR_CONTROL, r);
			chk(independent_mode, 32'h1);
		end
		bus(1, ADDR_CONTROL, 0);
		bus(1, ADDR_IRQ_MASK, 32'h10);
		for (int i = 0; i < 6; i++) begin
			pulse(i);
			chk(irq, i == 0);
			bus(0, ADDR_STATUS, fl[i]);
			bus(1, ADDR_STATUS, '1);
			bus(0, ADDR_STATUS, fl[i]);
			bus(1, ADDR_STATUS, 0);
			bus(0, ADDR_STATUS, 0);
		end
		for (int k = 0; k < 4; k++) begin
			bus(1, ADDR_CONTROL, (k & 1) << 23 - k / 2);
			@(posedge sys_clk) res <= k < 2 ?
				hi + 12'h001 + 12'($urandom % 99) : 12'($urandom % lo);
			pulse(k / 2 * 3 + 1);
			bus(0, ADDR_STATUS, fl[k / 2 * 3 + 1] | k & 1);
			bus(1, ADDR_STATUS, 0);
		end
		// Results on or inside the bounds never flag, both groups enabled
		bus(1, ADDR_CONTROL, 32'h00c0_0000);
		for (int k = 0; k < 4; k++) begin
			@(posedge sys_clk) res <= k < 2 ? (k ? hi : lo) :
				lo + 12'($urandom % (hi - lo + 1));
			pulse((k & 1) * 3 + 1);
			bus(0, ADDR_STATUS, fl[(k & 1) * 3 + 1]);
			bus(1, ADDR_STATUS, 0);
		end
		// Event and zero write in one cycle: the event must survive
		fork
			pulse(0);
			bus(1, ADDR_STATUS, 0);
		join
		bus(0, ADDR_STATUS, 32'h10);
		bus(1, ADDR_STATUS, 0);
		for (int k = 0; k < 3; k++) begin
			n = k ? $urandom % 8 : 7;
			bus(1, ADDR_CONTROL, n << 13 | (k < 2) << 11);
			pulse(6);
			for (int j = 0; j <= n; j++) begin
				pulse(1);
				chk(burst_done, k < 2 && j == n);
			end
		end
		end_of_test();
	end
endmodule // asc_regs_tb
bind asc_regs asc_regs_assertions chk_i (.sys_clk, .srst, .rd_stb, .wr_stb,
	.burst_done,
	.reg_conv_start, .reg_conv_end, .reg_seq_end, .inj_seq_start,
	.inj_conv_end, .inj_seq_end, .addr, .rdata);
